// >>> design/vuf_buf.sv
// Purpose: small word buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   in_ready low is the back-pressure toward the producer
`timescale 1ns/10ps

module vuf_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } vuf_buf_st_t;

    vuf_buf_st_t s_r;
    vuf_buf_st_t s_nxt;
    logic        push;
    logic        pop;

    // flags straight from the fill count
    assign in_ready  = (s_r.cnt != CW'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and count update
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = PW'(s_r.wp + PW'(1));
        end
        if (pop) begin
            s_nxt.rp = PW'(s_r.rp + PW'(1));
        end
        s_nxt.cnt = CW'(s_r.cnt + CW'(push) - CW'(pop));
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // vuf_buf

// >>> design/vuf_pkg.sv
// Purpose: constants, types and state records of the serial bridge block
// Assumes: 125 MHz CLK, APB slave with 8-bit byte address
// Notes:   shared by the bridge top, the receiver, the bench and the target model

package vuf_pkg;

    // =========================================================
    // timing
    localparam int unsigned CLK_HZ   = 125_000_000;
    localparam int unsigned BAUD_DEF = 115_200;
    localparam int unsigned BAUD_MIN = 9_600;
    localparam int unsigned BAUD_MAX = 921_600;
    localparam int          DIV_W    = 16;
    localparam logic [DIV_W-1:0] DIV_DEF = DIV_W'(CLK_HZ / BAUD_DEF);
    localparam logic [DIV_W-1:0] DIV_LO  = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_HI  = DIV_W'(CLK_HZ / BAUD_MIN);
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

    // =========================================================
    // character format
    localparam int         DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [2:0] BIT_ONE   = 3'h1;

    // =========================================================
    // register map
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_BAUD  = 8'h04;
    localparam logic [7:0] ADDR_TXDAT = 8'h08;
    localparam logic [7:0] ADDR_RXDAT = 8'h0c;
    localparam logic [7:0] ADDR_STAT  = 8'h10;
    localparam int CTRL_RXFC   = 0;
    localparam int CTRL_TXFC   = 1;
    localparam int RXDAT_VALID = 8;
    localparam int STS_TXBUSY  = 0;
    localparam int STS_TXFULL  = 1;
    localparam int STS_RXAVAIL = 2;
    localparam int STS_RXFULL  = 3;
    localparam int STS_OVR     = 4;
    localparam int STS_RDY     = 5;
    localparam int STS_FERR    = 6;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // =========================================================
    // types
    typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP}
        vuf_ser_st_t;

    typedef struct packed {
        logic       valid;
        logic       ferr;
        logic [7:0] data;
    } vuf_rxo_t;

    typedef struct packed {
        vuf_ser_st_t      st;
        logic [DIV_W-1:0] cnt;
        logic [2:0]       bitn;
        logic [7:0]       sh;
        vuf_rxo_t         o;
    } vuf_rx_st_t;

    typedef struct packed {
        logic             rxfc;
        logic             txfc;
        logic [DIV_W-1:0] div;
        vuf_ser_st_t      tx_st;
        logic [DIV_W-1:0] tx_cnt;
        logic [2:0]       tx_bit;
        logic [7:0]       tx_sh;
        logic             txd;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             permit;
        logic             permit_oe;
        logic             ovr;
        logic             ferr;
    } vuf_top_st_t;

    localparam vuf_rx_st_t RX_RST = '{st: SER_IDLE, default: '0};
    localparam vuf_top_st_t TOP_RST = '{tx_st: SER_IDLE, div: DIV_DEF,
                                        txd: 1'b1, default: '0};

endpackage

// >>> design/vuf_rx.sv
// Purpose: serial character receiver, mid-bit sampling
// Assumes: rxd synchronous to clk, div clocks per bit
// Notes:   valid and ferr are one-cycle pulses
`timescale 1ns/10ps

module vuf_rx
    import vuf_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   en,
    input  wire logic [vuf_pkg::DIV_W-1:0] div,
    input  wire logic                   rxd,
    output vuf_pkg::vuf_rxo_t           rx_out
);
    vuf_rx_st_t s_r;
    vuf_rx_st_t s_nxt;

    assign rx_out = s_r.o;

    // start detect, data shift, stop check
    always_comb begin
        s_nxt         = s_r;
        s_nxt.o.valid = 1'b0;
        s_nxt.o.ferr  = 1'b0;
        case (s_r.st)
            SER_IDLE: begin
                if (en && !rxd) begin
                    s_nxt.st  = SER_START;
                    s_nxt.cnt = div >> 1;
                end
            end
            SER_START: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st   = rxd ? SER_IDLE : SER_DATA;
                    s_nxt.cnt  = div - DIV_ONE;
                    s_nxt.bitn = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt - DIV_ONE;
                end
            end
            SER_DATA: begin
                if (s_r.cnt == '0) begin
                    s_nxt.sh  = {rxd, s_r.sh[7:1]};
                    s_nxt.cnt = div - DIV_ONE;
                    if (s_r.bitn == LAST_BIT) begin
                        s_nxt.st = SER_STOP;
                    end else begin
                        s_nxt.bitn = s_r.bitn + BIT_ONE;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - DIV_ONE;
                end
            end
            SER_STOP: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st      = SER_IDLE;
                    s_nxt.o.valid = rxd;
                    s_nxt.o.ferr  = !rxd;
                    s_nxt.o.data  = s_r.sh;
                end else begin
                    s_nxt.cnt = s_r.cnt - DIV_ONE;
                end
            end
            default: begin
                s_nxt.st = SER_IDLE;
            end
        endcase
        if (!en) begin
            s_nxt.st = SER_IDLE;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= RX_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // vuf_rx

// >>> design/vuf_uart_top.sv
// Purpose: target-facing serial port with optional line handshake
// Assumes: APB master, all pins synchronous to CLK
// Notes:   permit line is open-drive style: PERMIT_OE gates PERMIT_O
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps

module vuf_uart_top
    import vuf_pkg::*;
(
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [vuf_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic [31:0]                      PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    input  wire logic                        IF_EN,
    input  wire logic                        TGT_TXD,
    output logic                             TGT_RXD,
    output logic                             PERMIT_O,
    output logic                             PERMIT_OE,
    input  wire logic                        RDY_IN
);
    vuf_top_st_t s_r;
    vuf_top_st_t s_nxt;
    vuf_rxo_t    rx_o;
    logic        txb_in_valid;
    logic        txb_in_ready;
    logic        txb_out_valid;
    logic        txb_out_ready;
    logic [7:0]  txb_out_data;
    logic        rxb_in_ready;
    logic        rxb_out_valid;
    logic        rxb_out_ready;
    logic [7:0]  rxb_out_data;
    logic        acc;
    logic        hit;
    logic        may_send;
    logic [31:0] rd_mux;
    logic [31:0] stat;

    // =========================================================
    // outputs straight from the state register
    assign PRDATA    = s_r.prdata;
    assign PREADY    = s_r.pready;
    assign PSLVERR   = s_r.pslverr;
    assign TGT_RXD   = s_r.txd;
    assign PERMIT_O  = s_r.permit;
    assign PERMIT_OE = s_r.permit_oe;

    // =========================================================
    // buffers and receiver
    vuf_buf #(.W(8), .DEPTH(2)) u_txbuf (
        .clk       (CLK),
        .rst       (RESET),
        .in_valid  (txb_in_valid),
        .in_ready  (txb_in_ready),
        .in_data   (PWDATA[7:0]),
        .out_valid (txb_out_valid),
        .out_ready (txb_out_ready),
        .out_data  (txb_out_data)
    );

    vuf_buf #(.W(8), .DEPTH(2)) u_rxbuf (
        .clk       (CLK),
        .rst       (RESET),
        .in_valid  (rx_o.valid),
        .in_ready  (rxb_in_ready),
        .in_data   (rx_o.data),
        .out_valid (rxb_out_valid),
        .out_ready (rxb_out_ready),
        .out_data  (rxb_out_data)
    );

    vuf_rx u_rx (
        .clk    (CLK),
        .rst    (RESET),
        .en     (IF_EN),
        .div    (s_r.div),
        .rxd    (TGT_TXD),
        .rx_out (rx_o)
    );

    // =========================================================
    // bus decode and read mux
    assign acc = PSEL & PENABLE;
    assign hit = (PADDR == ADDR_CTRL) || (PADDR == ADDR_BAUD) ||
                 (PADDR == ADDR_TXDAT) || (PADDR == ADDR_RXDAT) ||
                 (PADDR == ADDR_STAT);

    // status word
    always_comb begin
        stat              = RD_ZERO;
        stat[STS_TXBUSY]  = (s_r.tx_st != SER_IDLE);
        stat[STS_TXFULL]  = !txb_in_ready;
        stat[STS_RXAVAIL] = rxb_out_valid;
        stat[STS_RXFULL]  = !rxb_in_ready;
        stat[STS_OVR]     = s_r.ovr;
        stat[STS_RDY]     = RDY_IN;
        stat[STS_FERR]    = s_r.ferr;
    end

    // read data selection
    always_comb begin
        rd_mux = RD_ZERO;
        case (PADDR)
            ADDR_CTRL: begin
                rd_mux[CTRL_RXFC] = s_r.rxfc;
                rd_mux[CTRL_TXFC] = s_r.txfc;
            end
            ADDR_BAUD: begin
                rd_mux[DIV_W-1:0] = s_r.div;
            end
            ADDR_RXDAT: begin
                rd_mux[7:0]         = rxb_out_data;
                rd_mux[RXDAT_VALID] = rxb_out_valid;
            end
            ADDR_STAT: begin
                rd_mux = stat;
            end
            default: begin
                rd_mux = RD_ZERO;
            end
        endcase
    end

    // push and pop happen on the edge that completes the transfer
    assign txb_in_valid  = s_r.pready & acc & PWRITE & (PADDR == ADDR_TXDAT);
    assign rxb_out_ready = s_r.pready & acc & !PWRITE &
                           (PADDR == ADDR_RXDAT);

    // transmit gate: interface enable and optional ready line
    assign may_send = IF_EN & (!s_r.txfc | RDY_IN);
    assign txb_out_ready = (s_r.tx_st == SER_IDLE) & may_send;

    // =========================================================
    // next-state logic
    always_comb begin
        s_nxt         = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;

        // bus: answer one cycle into access, hold off on full buffer
        if (s_r.pready) begin
            if (acc && PWRITE) begin
                case (PADDR)
                    ADDR_CTRL: begin
                        s_nxt.rxfc = PWDATA[CTRL_RXFC];
                        s_nxt.txfc = PWDATA[CTRL_TXFC];
                    end
                    ADDR_BAUD: begin
                        if (PWDATA[DIV_W-1:0] < DIV_LO) begin
                            s_nxt.div = DIV_LO;
                        end else if (PWDATA[DIV_W-1:0] > DIV_HI) begin
                            s_nxt.div = DIV_HI;
                        end else begin
                            s_nxt.div = PWDATA[DIV_W-1:0];
                        end
                    end
                    ADDR_STAT: begin
                        s_nxt.ovr  = s_r.ovr & !PWDATA[STS_OVR];
                        s_nxt.ferr = s_r.ferr & !PWDATA[STS_FERR];
                    end
                    default: begin
                        s_nxt.ovr = s_r.ovr;
                    end
                endcase
            end
        end else if (acc) begin
            if (!(PWRITE && PADDR == ADDR_TXDAT && !txb_in_ready)) begin
                s_nxt.pready  = 1'b1;
                s_nxt.pslverr = !hit;
                s_nxt.prdata  = PWRITE ? RD_ZERO : rd_mux;
            end
        end

        // sticky errors: a new event wins over the clear
        if (rx_o.valid && !rxb_in_ready) begin
            s_nxt.ovr = 1'b1;
        end
        if (rx_o.ferr) begin
            s_nxt.ferr = 1'b1;
        end

        // permit line: driven only in receive handshake modes
        s_nxt.permit_oe = s_r.rxfc;
        s_nxt.permit    = rxb_in_ready;

        // transmitter: a started character always runs to its stop bit
        case (s_r.tx_st)
            SER_IDLE: begin
                s_nxt.txd = 1'b1;
                if (txb_out_valid && may_send) begin
                    s_nxt.tx_st  = SER_START;
                    s_nxt.tx_sh  = txb_out_data;
                    s_nxt.txd    = 1'b0;
                    s_nxt.tx_cnt = s_r.div - DIV_ONE;
                end
            end
            SER_START: begin
                if (s_r.tx_cnt == '0) begin
                    s_nxt.tx_st  = SER_DATA;
                    s_nxt.txd    = s_r.tx_sh[0];
                    s_nxt.tx_bit = '0;
                    s_nxt.tx_cnt = s_r.div - DIV_ONE;
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - DIV_ONE;
                end
            end
            SER_DATA: begin
                if (s_r.tx_cnt == '0) begin
                    s_nxt.tx_cnt = s_r.div - DIV_ONE;
                    if (s_r.tx_bit == LAST_BIT) begin
                        s_nxt.tx_st = SER_STOP;
                        s_nxt.txd   = 1'b1;
                    end else begin
                        s_nxt.tx_bit = s_r.tx_bit + BIT_ONE;
                        s_nxt.tx_sh  = s_r.tx_sh >> 1;
                        s_nxt.txd    = s_r.tx_sh[1];
                    end
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - DIV_ONE;
                end
            end
            SER_STOP: begin
                if (s_r.tx_cnt == '0) begin
                    s_nxt.tx_st = SER_IDLE;
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - DIV_ONE;
                end
            end
            default: begin
                s_nxt.tx_st = SER_IDLE;
                s_nxt.txd   = 1'b1;
            end
        endcase
    end

    // state register, reset to default format and no handshake
    always_ff @(posedge CLK) begin
        if (RESET) begin
            s_r <= TOP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =========================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_RESET_DEFAULT: assert property (disable iff (1'b0)
        RESET |=> (s_r.div == DIV_DEF && !s_r.rxfc && !s_r.txfc &&
                   !PERMIT_OE && TGT_RXD))
        else $error("reset did not restore default format");

    AST_DIV_RANGE: assert property (
        s_r.div >= DIV_LO && s_r.div <= DIV_HI)
        else $error("bit divisor out of allowed range");

    AST_PERMIT_MODE: assert property (
        PERMIT_OE == $past(s_r.rxfc))
        else $error("permit enable does not follow receive mode");

    AST_PERMIT_FULL: assert property (
        !rxb_in_ready |=> !PERMIT_O)
        else $error("permit high while receive buffer full");

    AST_TX_HOLD: assert property (
        (s_r.tx_st == SER_IDLE && s_r.txfc && !RDY_IN)
        |=> s_r.tx_st == SER_IDLE)
        else $error("character started while target not ready");

    AST_NO_ABORT: assert property (
        (s_r.tx_st != SER_IDLE && !RDY_IN && s_r.tx_cnt != '0)
        |=> s_r.tx_cnt == $past(s_r.tx_cnt) - DIV_ONE)
        else $error("character paused or aborted mid-flight");

    AST_IGNORE_RDY: assert property (
        (s_r.tx_st == SER_IDLE && !s_r.txfc && IF_EN && txb_out_valid)
        |=> s_r.tx_st == SER_START ##0 !TGT_RXD)
        else $error("transmit held although handshake is off");

    AST_IF_GATE: assert property (
        (s_r.tx_st == SER_IDLE && !IF_EN) |=> s_r.tx_st == SER_IDLE)
        else $error("character sent while interface disabled");

    AST_FRAME_LEVELS: assert property (
        (s_r.tx_st == SER_START |-> !TGT_RXD) and
        (s_r.tx_st != SER_DATA && s_r.tx_st != SER_START |-> TGT_RXD))
        else $error("start, stop or idle level wrong");

    AST_PREADY_PULSE: assert property (
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    COV_TX_HANDSHAKE: cover property (
        s_r.txfc && !RDY_IN ##1 RDY_IN ##1 s_r.tx_st == SER_START);
    COV_RX_BYTE: cover property (rx_o.valid && rxb_in_ready);
    COV_OVERRUN: cover property (rx_o.valid && !rxb_in_ready);
    COV_TX_STALL: cover property (acc && PWRITE && !txb_in_ready);

endmodule // vuf_uart_top

// >>> test/tb.sv
// Purpose: self-checking bench of the serial bridge top
// Assumes: target model on the serial side, APB on the host side
// Notes:   divisor lowered to the fastest rate after the first character
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value t=%0t got %h", $time, (a)); end end

module tb;
    import vuf_pkg::*;
    logic        clk, reset, psel, penable, pwrite, if_en, rdy_in, sl;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, tgt_txd, tgt_rxd, permit_o, permit_oe;
    int          err_count  = 0;
    int          n_compared = 0;
    wire         permit     = permit_oe ? permit_o : 1'b1;

    vuf_uart_top i_dut (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IF_EN(if_en), .TGT_TXD(tgt_txd),
        .TGT_RXD(tgt_rxd), .PERMIT_O(permit_o), .PERMIT_OE(permit_oe),
        .RDY_IN(rdy_in));
    vuf_tgt_model i_tgt (.clk(clk), .rxd(tgt_rxd), .permit(permit),
        .txd(tgt_txd));

    // =========================================================
    // bus and helper tasks
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q  = prdata;
        sl = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_got(input int n0);
        for (int i = 0; i < 20000 && i_tgt.n_got == n0; i++) @(posedge clk);
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic t_reset();
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        apb(1'b0, ADDR_BAUD, 32'h0000_0000);
        `CHK(q[15:0], DIV_DEF)
        `CHK(permit_oe, 1'b0)
        `CHK(tgt_rxd, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_tx_free();
        int n0;
        rdy_in <= 1'b0;
        n0 = i_tgt.n_got;
        apb(1'b1, ADDR_TXDAT, 32'h0000_00a5);
        wait_got(n0);
        `CHK(i_tgt.got, 8'ha5)
        `CHK(i_tgt.n_got, n0 + 1)
        $display("test free send done");
    endtask

    task automatic t_baud();
        apb(1'b1, ADDR_BAUD, 32'h0000_0001);
        apb(1'b0, ADDR_BAUD, 32'h0000_0000);
        `CHK(q[15:0], DIV_LO)
        apb(1'b1, ADDR_BAUD, 32'h0000_ffff);
        apb(1'b0, ADDR_BAUD, 32'h0000_0000);
        `CHK(q[15:0], DIV_HI)
        apb(1'b1, ADDR_BAUD, {16'h0000, DIV_LO});
        i_tgt.div = int'(DIV_LO);
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK(sl, 1'b1)
        `CHK(q, 32'h0000_0000)
        $display("test baud done");
    endtask

    task automatic t_tx_fc();
        int n0;
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        n0 = i_tgt.n_got;
        apb(1'b1, ADDR_TXDAT, 32'h0000_003c);
        repeat (2500) @(posedge clk);
        `CHK(tgt_rxd, 1'b1)
        `CHK(i_tgt.n_got, n0)
        `CHK(permit_oe, 1'b0)
        rdy_in <= 1'b1;
        for (int i = 0; i < 100 && tgt_rxd !== 1'b0; i++) @(posedge clk);
        repeat (300) @(posedge clk);
        rdy_in <= 1'b0;
        wait_got(n0);
        `CHK(i_tgt.got, 8'h3c)
        `CHK(i_tgt.n_got, n0 + 1)
        $display("test send handshake done");
    endtask

    task automatic t_rx_fc();
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK(permit_oe, 1'b1)
        `CHK(permit_o, 1'b1)
        i_tgt.send(8'h5a);
        i_tgt.send(8'hc3);
        repeat (200) @(posedge clk);
        `CHK(permit_o, 1'b0)
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        `CHK(q, 32'h0000_000c)
        apb(1'b0, ADDR_RXDAT, 32'h0000_0000);
        `CHK(q, 32'h0000_015a)
        repeat (2) @(posedge clk);
        `CHK(permit_o, 1'b1)
        apb(1'b0, ADDR_RXDAT, 32'h0000_0000);
        `CHK(q, 32'h0000_01c3)
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        `CHK(permit_oe, 1'b0)
        $display("test receive handshake done");
    endtask

    task automatic t_ifen();
        int n0;
        if_en <= 1'b0;
        n0 = i_tgt.n_got;
        apb(1'b1, ADDR_TXDAT, 32'h0000_0081);
        repeat (1500) @(posedge clk);
        `CHK(i_tgt.n_got, n0)
        if_en <= 1'b1;
        wait_got(n0);
        `CHK(i_tgt.got, 8'h81)
        $display("test interface enable done");
    endtask

    // =========================================================
    // clock, main sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {reset, psel, penable, pwrite, if_en, rdy_in} <= 6'b100011;
        paddr  <= 8'h00;
        pwdata <= 32'h0000_0000;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_tx_free();
        t_baud();
        t_tx_fc();
        t_rx_fc();
        t_ifen();
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule // tb

// >>> test/vuf_tgt_model.sv
// Purpose: behavioural target-side serial port with a permit line
// Assumes: bit time of div clocks, set by the bench to match the bridge
// Notes:   permit line is pulled up when the bridge does not drive it
`timescale 1ns/10ps

module vuf_tgt_model (
    input  wire logic clk,
    input  wire logic rxd,
    input  wire logic permit,
    output logic      txd
);
    int         div   = int'(vuf_pkg::DIV_DEF);
    logic [7:0] got   = 8'h00;
    int         n_got = 0;

    // =========================================================
    // transmit: waits for permit, then one framed character
    initial txd = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (permit !== 1'b1) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            txd <= f[i];
            repeat (div) @(posedge clk);
        end
    endtask

    // =========================================================
    // receive: always ready for one more character
    always begin
        @(posedge clk);
        if (rxd === 1'b0) begin
            repeat (div / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge clk);
                got[i] = rxd;
            end
            repeat (div) @(posedge clk);
            if (rxd === 1'b1) n_got++;
        end
    end
endmodule // vuf_tgt_model
